// file: core/ccpa_consts.vh
`ifndef CCPA_CONSTS_VH
`define CCPA_CONSTS_VH

// ---------------------------------------------------------------
// Register byte addresses (6-bit address space)
// ---------------------------------------------------------------
`define CCPA_A_MODE     6'h00
`define CCPA_A_CNT_HI   6'h04
`define CCPA_A_CNT_LO   6'h05
`define CCPA_A_TSC      6'h06
`define CCPA_A_PSC      6'h0d
`define CCPA_A_CFLG     6'h0e
`define CCPA_A_VAL_BASE 6'h10
`define CCPA_A_ACCTL    6'h20
`define CCPA_A_ACFLG    6'h21
`define CCPA_A_ACCNT_HI 6'h22
`define CCPA_A_ACCNT_LO 6'h23

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CCPA_TSC_EN     7
`define CCPA_PA_EN      6
`define CCPA_PA_MOD     5
`define CCPA_PA_EDGE    4
`define CCPA_PA_CLK_HI  3
`define CCPA_PA_CLK_LO  2
`define CCPA_PA_OVI     1
`define CCPA_PA_INI     0
`define CCPA_FLG_OVF    1
`define CCPA_FLG_INF    0

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define CCPA_RST8       8'h00
`define CCPA_RST16      16'h0000
`define CCPA_CLK_PRESC  2'b00
`define CCPA_CLK_PA     2'b01
`define CCPA_CLK_PA256  2'b10
`define CCPA_CLK_PA64K  2'b11

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define CCPA_DIV64_MASK 7'h3f
`define CCPA_LOW_FULL   8'hff
`define CCPA_WORD_FULL  16'hffff

`endif

// file: core/ccpa_top.v
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccpa_consts.vh"

// Overview of operation
// R1 - Channels capture counter or drive compare action
// R2 - Value writes stored only in compare mode
// R3 - Channel values reset to zero
// R4 - Software accesses high byte before low
// R5 - Accumulator enable independent of timer enable
// R6 - Accumulator input is channel seven pin
// R7 - Mode bit: event count or gated time
// R8 - Event mode edge polarity selects counted edge
// R9 - Gated level enables div64; trailing edge flags
// R10 - Div64 tick only while timer enabled
// R11 - Clock select picks counter clock source
// R12 - Accumulator off forces prescaler clock
// R13 - Clock select change takes effect immediately
// R14 - Overflow flag with enable requests interrupt
// R15 - Input flag with enable requests interrupt
// R16 - Control register readable, writable any time
// R17 - Count wrap sets overflow flag
// R18 - Count synchronized active input edges
// R19 - Gated mode counts div64 ticks while active
module ccpa_top (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       wb_cyc_i,
   input  wire       wb_stb_i,
   input  wire       wb_we_i,
   input  wire [5:0] wb_adr_i,
   input  wire [7:0] wb_dat_i,
   input  wire       wb_sel_i,
   output reg  [7:0] wb_dat_o,
   output reg        wb_ack_o,
   input  wire [7:0] chan_pin_i,
   output reg  [7:0] chan_out_o,
   output reg  [7:0] chan_flag_o,
   output reg        pa_irq_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Prescaler stage mask for a divide by two to the power sel
   function [6:0] presc_mask;
      input [2:0] sel;
      begin
         presc_mask = (7'h01 << sel) - 7'h01;
      end
   endfunction

   // Edge of the selected polarity: pol 1 rising, 0 falling
   function edge_of;
      input pol;
      input now;
      input was;
      begin
         edge_of = pol ? (now & ~was) : (~now & was);
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg  [7:0]   channel_mode_select;
   reg          main_timer_enable;
   reg  [2:0]   presc_sel;
   reg  [7:0]   pulse_accum_control;
   reg          accumulator_overflow_flag;
   reg          input_edge_flag;
   reg  [15:0]  accumulator_count;
   reg  [15:0]  free_count;
   reg  [6:0]   presc_cnt;
   reg  [7:0]   pin_s1;
   reg  [7:0]   pin_s2;
   reg  [7:0]   pin_s3;
   reg          tick_d;
   reg          pend;
   reg  [7:0]   rd_buf;
   reg  [7:0]   wr_buf;
   wire [15:0]  mem_rd;
   wire [127:0] mem_all;
   reg  [7:0]   val_wr_en;
   reg  [7:0]   cap_en;
   reg  [7:0]   cmp_hit;
   integer      i;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Two-cycle answer: the value memory reads through a register
   wire req      = wb_cyc_i & wb_stb_i;
   wire wr_stb   = pend & wb_we_i & wb_sel_i;
   wire rd_stb   = pend & ~wb_we_i;
   wire is_val   = (wb_adr_i[5:4] == `CCPA_A_VAL_BASE >> 4);
   wire flag_clr = main_timer_enable | pulse_accum_control[`CCPA_PA_EN];
   wire pa_en    = pulse_accum_control[`CCPA_PA_EN];
   wire pa_mod   = pulse_accum_control[`CCPA_PA_MOD];
   wire pa_edge  = pulse_accum_control[`CCPA_PA_EDGE];
   wire [1:0] clk_sel = pulse_accum_control[`CCPA_PA_CLK_HI:`CCPA_PA_CLK_LO];

   // Bus phase: pend one cycle, then ack one cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         pend     <= 1'b0;
         wb_ack_o <= 1'b0;
      end else begin
         pend     <= req & ~pend & ~wb_ack_o;
         wb_ack_o <= pend;
      end
   end

   // ------------------------------------------------------------
   // Prescaler and input synchronisers
   // ------------------------------------------------------------
   // New divisor acts at the next point where masked stages are all ones
   wire presc_tick = main_timer_enable &
                     ((presc_cnt & presc_mask(presc_sel)) == presc_mask(presc_sel));
   // R10 - div64 needs timer
   wire div64_tick = main_timer_enable &
                     ((presc_cnt & `CCPA_DIV64_MASK) == `CCPA_DIV64_MASK);

   always @(posedge clk_i) begin
      if (rst_i) begin
         presc_cnt <= 7'h00;
         pin_s1    <= `CCPA_RST8;
         pin_s2    <= `CCPA_RST8;
         pin_s3    <= `CCPA_RST8;
      end else begin
         presc_cnt <= main_timer_enable ? presc_cnt + 7'h01 : 7'h00;
         pin_s1    <= chan_pin_i;
         pin_s2    <= pin_s1;
         pin_s3    <= pin_s2;
      end
   end

   // ------------------------------------------------------------
   // Pulse accumulator
   // ------------------------------------------------------------
   // R6 - channel seven pin
   wire pa_now  = pin_s2[7];
   wire pa_was  = pin_s3[7];
   // R8 - edge polarity
   wire ev_edge = edge_of(pa_edge, pa_now, pa_was);
   // R9 - trailing gate edge
   wire trail   = edge_of(~pa_edge, ~pa_now, ~pa_was);
   wire gate_on = pa_edge ? ~pa_now : pa_now;
   // R7 - mode select
   // R19 - gated ticks
   wire pa_inc  = pa_en & (pa_mod ? (div64_tick & gate_on) : ev_edge);
   wire inf_set = pa_en & (pa_mod ? trail : ev_edge);
   wire ovf_set = pa_inc & (accumulator_count == `CCPA_WORD_FULL);
   wire wr_pafl = wr_stb & (wb_adr_i == `CCPA_A_ACFLG) & flag_clr;
   // R5 - event mode runs without timer
   // R18 - count edges
   always @(posedge clk_i) begin
      if (rst_i) begin
         accumulator_count <= `CCPA_RST16;
      end else if (wr_stb & (wb_adr_i == `CCPA_A_ACCNT_LO)) begin
         accumulator_count <= {wr_buf, wb_dat_i};
      end else if (pa_inc) begin
         accumulator_count <= accumulator_count + 16'h0001;
      end
   end

   // Set wins over a same-cycle clear
   // R17 - wrap sets overflow
   always @(posedge clk_i) begin
      if (rst_i) begin
         accumulator_overflow_flag <= 1'b0;
         input_edge_flag           <= 1'b0;
      end else begin
         accumulator_overflow_flag <= ovf_set |
            (accumulator_overflow_flag & ~(wr_pafl & wb_dat_i[`CCPA_FLG_OVF]));
         input_edge_flag <= inf_set |
            (input_edge_flag & ~(wr_pafl & wb_dat_i[`CCPA_FLG_INF]));
      end
   end

   // R14 - overflow request
   // R15 - input request
   always @(posedge clk_i) begin
      if (rst_i) begin
         pa_irq_o <= 1'b0;
      end else begin
         pa_irq_o <= (accumulator_overflow_flag & pulse_accum_control[`CCPA_PA_OVI]) |
                     (input_edge_flag & pulse_accum_control[`CCPA_PA_INI]);
      end
   end

   // ------------------------------------------------------------
   // Free-running counter clock select
   // ------------------------------------------------------------
   // R11 - clock source
   // R12 - disabled forces prescaler
   // R13 - no boundary wait
   reg cnt_tick;
   always @* begin
      cnt_tick = presc_tick;
      if (pa_en) begin
         case (clk_sel)
            `CCPA_CLK_PRESC: cnt_tick = presc_tick;
            `CCPA_CLK_PA:    cnt_tick = pa_inc;
            `CCPA_CLK_PA256: cnt_tick = pa_inc &
                                        (accumulator_count[7:0] == `CCPA_LOW_FULL);
            `CCPA_CLK_PA64K: cnt_tick = ovf_set;
            default:         cnt_tick = presc_tick;
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         free_count <= `CCPA_RST16;
         tick_d     <= 1'b0;
      end else begin
         tick_d <= cnt_tick;
         if (cnt_tick) begin
            free_count <= free_count + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Capture and compare per channel
   // ------------------------------------------------------------
   // Capture on rising synchronised edges only; channels have no edge select
   always @* begin
      val_wr_en = 8'h00;
      cap_en    = 8'h00;
      cmp_hit   = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
         // R1 - capture or compare
         cap_en[i]  = main_timer_enable & ~channel_mode_select[i] &
                      pin_s2[i] & ~pin_s3[i];
         cmp_hit[i] = main_timer_enable & channel_mode_select[i] & tick_d &
                      (mem_all[i*16 +: 16] == free_count);
         // R2 - compare-only writes
         val_wr_en[i] = wr_stb & is_val & wb_adr_i[0] &
                        (wb_adr_i[3:1] == i[2:0]) & channel_mode_select[i];
      end
   end

   ccpa_value_mem u_mem (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (val_wr_en),
      .wr_val_i  ({wr_buf, wb_dat_i}),
      .cap_en_i  (cap_en),
      .cap_val_i (free_count),
      .rd_idx_i  (wb_adr_i[3:1]),
      .rd_val_o  (mem_rd),
      .all_val_o (mem_all)
   );

   // Compare toggles the output; capture and compare both flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         chan_out_o  <= `CCPA_RST8;
         chan_flag_o <= `CCPA_RST8;
      end else begin
         chan_out_o  <= chan_out_o ^ cmp_hit;
         chan_flag_o <= cap_en | cmp_hit | (chan_flag_o &
            ~((wr_stb & (wb_adr_i == `CCPA_A_CFLG) & flag_clr) ? wb_dat_i : 8'h00));
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   // R16 - any-time access
   always @(posedge clk_i) begin
      if (rst_i) begin
         channel_mode_select <= `CCPA_RST8;
         main_timer_enable   <= 1'b0;
         presc_sel           <= 3'h0;
         pulse_accum_control <= `CCPA_RST8;
         wr_buf              <= `CCPA_RST8;
      end else if (wr_stb) begin
         case (wb_adr_i)
            `CCPA_A_MODE:     channel_mode_select <= wb_dat_i;
            `CCPA_A_TSC:      main_timer_enable <= wb_dat_i[`CCPA_TSC_EN];
            `CCPA_A_PSC:      presc_sel <= wb_dat_i[2:0];
            `CCPA_A_ACCTL:    pulse_accum_control <= {1'b0, wb_dat_i[6:0]};
            `CCPA_A_ACCNT_HI: wr_buf <= wb_dat_i;
            default: begin
               // High half of a value word waits for its low half
               if (is_val & ~wb_adr_i[0]) begin
                  wr_buf <= wb_dat_i;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Low byte comes from the buffer, so out-of-order reads see stale data
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= `CCPA_RST8;
         rd_buf   <= `CCPA_RST8;
      end else if (rd_stb) begin
         case (wb_adr_i)
            `CCPA_A_MODE:     wb_dat_o <= channel_mode_select;
            `CCPA_A_CNT_HI: begin
               wb_dat_o <= free_count[15:8];
               rd_buf   <= free_count[7:0];
            end
            `CCPA_A_CNT_LO:   wb_dat_o <= rd_buf;
            `CCPA_A_TSC:      wb_dat_o <= {main_timer_enable, 7'h00};
            `CCPA_A_PSC:      wb_dat_o <= {5'h00, presc_sel};
            `CCPA_A_CFLG:     wb_dat_o <= chan_flag_o;
            `CCPA_A_ACCTL:    wb_dat_o <= pulse_accum_control;
            `CCPA_A_ACFLG:    wb_dat_o <= {6'h00, accumulator_overflow_flag,
                                           input_edge_flag};
            `CCPA_A_ACCNT_HI: begin
               wb_dat_o <= accumulator_count[15:8];
               rd_buf   <= accumulator_count[7:0];
            end
            `CCPA_A_ACCNT_LO: wb_dat_o <= rd_buf;
            default: begin
               if (is_val & ~wb_adr_i[0]) begin
                  wb_dat_o <= mem_rd[15:8];
                  rd_buf   <= mem_rd[7:0];
               end else if (is_val) begin
                  wb_dat_o <= rd_buf;
               end else begin
                  wb_dat_o <= 8'h00;
               end
            end
         endcase
      end
   end
endmodule

`default_nettype wire

// file: core/ccpa_value_mem.v
`timescale 1ns/10ps
`default_nettype none

// Eight 16-bit channel value words, registered read port
module ccpa_value_mem (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire [7:0]   wr_en_i,
   input  wire [15:0]  wr_val_i,
   input  wire [7:0]   cap_en_i,
   input  wire [15:0]  cap_val_i,
   input  wire [2:0]   rd_idx_i,
   output reg  [15:0]  rd_val_o,
   output wire [127:0] all_val_o
);

   reg [15:0] mem [0:7];
   integer    k;

   // Flat view feeds the comparators of every channel at once
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : flat
         assign all_val_o[g*16 +: 16] = mem[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // R3 - zero at reset
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (k = 0; k < 8; k = k + 1) begin
            mem[k] <= `CCPA_RST16;
         end
         rd_val_o <= `CCPA_RST16;
      end else begin
         for (k = 0; k < 8; k = k + 1) begin
            // R1 - capture latch
            if (cap_en_i[k]) begin
               mem[k] <= cap_val_i;
            end else if (wr_en_i[k]) begin
               mem[k] <= wr_val_i;
            end
         end
         rd_val_o <= mem[rd_idx_i];
      end
   end

endmodule

`default_nettype wire

// file: test/ccpa_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Pulse source on the shared pin
// ----------------------------------------
module ccpa_pin_model (
   input  wire logic clk_i,
   output var  logic pin_o
);
   initial pin_o = 1'b0;

   // Whole pulses, four cycles a phase so the synchroniser sees each
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_i) pin_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         pin_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask

   // Hold a gate level, then fall back to idle low
   task automatic hold(input logic v, input int n);
      @(posedge clk_i) pin_o <= v;
      repeat (n) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

// file: test/ccpa_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccpa_consts.vh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module ccpa_properties (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic       wb_sel_i,
   input wire logic [7:0] wb_dat_o,
   input wire logic       wb_ack_o,
   input wire logic [7:0] chan_pin_i,
   input wire logic [7:0] chan_out_o,
   input wire logic [7:0] chan_flag_o,
   input wire logic       pa_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Ack comes two cycles after the request and lasts one
   sequence s_ack_walk;
      !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_flag_clear_write;
      wb_ack_o && wb_we_i && wb_adr_i == `CCPA_A_CFLG;
   endsequence

   a_ack_walk: assert property (
      $rose(wb_cyc_i && wb_stb_i) |=> s_ack_walk) else $error("ack timing wrong");
   a_ack_in_req: assert property (
      wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack outside request");
   a_reset_clear: assert property (
      $fell(rst_i) |-> chan_flag_o == 8'h00 && chan_out_o == 8'h00 && !pa_irq_o)
      else $error("outputs not clear after reset");
   a_flag_sticky: assert property (
      |($past(chan_flag_o) & ~chan_flag_o) |-> s_flag_clear_write)
      else $error("channel flag fell without clear");
   a_out_flag: assert property (
      ((chan_out_o ^ $past(chan_out_o)) & ~chan_flag_o) == 8'h00)
      else $error("compare toggle without flag");
   a_irq_drop: assert property (
      $fell(pa_irq_o) |-> $past(wb_ack_o && wb_we_i)) else $error("irq fell alone");
   a_unmapped_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 6'h3f |-> wb_dat_o == 8'h00)
      else $error("unmapped read not zero");
   a_ctl_top_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == `CCPA_A_ACCTL |-> !wb_dat_o[7])
      else $error("control bit 7 not zero");
endmodule

bind ccpa_top ccpa_properties u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_pin_i(chan_pin_i),
   .chan_out_o(chan_out_o), .chan_flag_o(chan_flag_o), .pa_irq_o(pa_irq_o));

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic        clk_i, rst_i, cyc, stb, we;
   logic [5:0]  adr;
   logic [7:0]  dat, dat_o, chan_out, chan_flag;
   logic [6:0]  pins;
   logic        ack, irq;
   wire logic   pin7;
   int          bad_count, total_checks;

   ccpa_pin_model pm (.clk_i(clk_i), .pin_o(pin7));
   ccpa_top dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(1'b1), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .chan_pin_i({pin7, pins}), .chan_out_o(chan_out),
      .chan_flag_o(chan_flag), .pa_irq_o(irq));

   // 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One classic cycle; held until ack is sampled, bounded wait
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         print_verdict;
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      bus(1'b0, a, 8'h00, q);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      rd(a, q);
      chk({8'h00, q}, {8'h00, e});
   endtask
   task automatic wr16(input logic [5:0] a, input logic [15:0] d);
      wr(a, d[15:8]);
      wr(a | 6'h01, d[7:0]);
   endtask
   task automatic rd16(input logic [5:0] a, output logic [15:0] q);
      rd(a, q[15:8]);
      rd(a | 6'h01, q[7:0]);
   endtask
   task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      chk({15'h0, (v >= lo && v <= hi)}, 16'h0001);
   endtask
   task automatic waitf(input int i);
      int n;
      n = 0;
      while (chan_flag[i] !== 1'b1 && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 600) begin
         bad_count++;
         print_verdict;
      end
   endtask

   task automatic t_reset;
      logic [15:0] v;
      for (int i = 0; i < 8; i++) begin
         rd16(6'h10 + 6'(2 * i), v);
         chk(v, 16'h0000);
      end
      rchk(6'h20, 8'h00);
      rchk(6'h3f, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_value;
      logic [15:0] v;
      wr(6'h00, 8'h01);
      wr16(6'h10, 16'h1234);
      rd16(6'h10, v);
      chk(v, 16'h1234);
      wr16(6'h12, 16'habcd);
      rd16(6'h12, v);
      chk(v, 16'h0000);
      wr(6'h20, 8'hff);
      rchk(6'h20, 8'h7f);
      wr(6'h20, 8'h00);
      $display("value test done");
   endtask

   task automatic t_compare;
      logic [15:0] v;
      wr16(6'h10, 16'h0100);
      wr(6'h06, 8'h80);
      waitf(0);
      @(posedge clk_i);
      chk(chan_out[0], 1'b1);
      wr(6'h0e, 8'h01);
      chk(chan_flag[0], 1'b0);
      pins[1] <= 1'b1;
      waitf(1);
      rd16(6'h12, v);
      rng(v, 16'h0101, 16'h0140);
      pins[1] <= 1'b0;
      wr(6'h0e, 8'h03);
      $display("compare test done");
   endtask

   task automatic t_event;
      logic [15:0] v;
      wr(6'h06, 8'h00);
      wr16(6'h22, 16'h0000);
      wr(6'h20, 8'h40);
      pm.pulses(4);
      rd16(6'h22, v);
      chk(v, 16'h0004);
      wr(6'h20, 8'h50);
      pm.pulses(2);
      rd16(6'h22, v);
      chk(v, 16'h0006);
      wr(6'h20, 8'h10);
      pm.pulses(2);
      rd16(6'h22, v);
      chk(v, 16'h0006);
      $display("event test done");
   endtask

   task automatic t_gated;
      logic [15:0] v;
      wr(6'h20, 8'h60);
      wr(6'h21, 8'h03);
      wr16(6'h22, 16'h0000);
      pm.hold(1'b1, 200);
      rd16(6'h22, v);
      chk(v, 16'h0000);
      rchk(6'h21, 8'h01);
      wr(6'h06, 8'h80);
      pm.hold(1'b1, 320);
      rd16(6'h22, v);
      rng(v, 16'h0004, 16'h0006);
      wr(6'h20, 8'h70);
      wr16(6'h22, 16'h0000);
      repeat (320) @(posedge clk_i);
      rd16(6'h22, v);
      rng(v, 16'h0004, 16'h0006);
      $display("gated test done");
   endtask

   task automatic t_clksel;
      logic [15:0] c0, c1;
      logic [15:0] pre [1:3] = '{16'h0000, 16'h00fe, 16'hfffe};
      logic [15:0] exp [1:3] = '{16'h0003, 16'h0001, 16'h0001};
      for (int k = 1; k < 4; k++) begin
         wr(6'h20, 8'h50 | 8'(k << 2));
         wr16(6'h22, pre[k]);
         rd16(6'h04, c0);
         pm.pulses(3);
         rd16(6'h04, c1);
         chk(c1 - c0, exp[k]);
      end
      wr(6'h20, 8'h04);
      rd16(6'h04, c0);
      rd16(6'h04, c1);
      rng(c1 - c0, 16'h0004, 16'h0014);
      $display("clock select test done");
   endtask

   task automatic t_irq;
      wr(6'h20, 8'h40);
      rchk(6'h21, 8'h03);
      chk(irq, 1'b0);
      wr(6'h20, 8'h42);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      wr(6'h21, 8'h02);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      wr(6'h20, 8'h41);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      wr(6'h20, 8'h40);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      $display("irq test done");
   endtask

   // Main sequence
   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      dat = 8'h00;
      pins = 7'h00;
      bad_count = 0;
      total_checks = 0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_value;
      t_compare;
      t_event;
      t_gated;
      t_clksel;
      t_irq;
      print_verdict;
   end
endmodule

`default_nettype wire
